// ---- hdl/stv_defines.vh ----
// Constants for the receiver pattern verifier status block.
// Included by the design files; holds definitions only.
`ifndef STV_DEFINES_VH
`define STV_DEFINES_VH
// Test modes
`define STV_MODE_SELFTEST 1'b0
`define STV_MODE_PRBS 1'b1
// Least error-flag hold in pseudo-random mode, recovered-clock cycles
`define STV_ERR_HOLD_CYC 2'h3
// Calibration timing: settle count after power-up, clocks
`define STV_CAL_SETTLE 4'h8
// Verifier states
`define STV_ST_IDLE 2'h0
`define STV_ST_RUN 2'h1
`define STV_ST_DONE 2'h2
// Calibration states
`define STV_CAL_OFF 2'h0
`define STV_CAL_SETTLING 2'h1
`define STV_CAL_READY 2'h2
`endif

// ---- hdl/stv_cal_block.v ----
// Calibration block control, run from its own calibration clock.
// Assumes the power-down input comes from outside its clock domain.
`timescale 1ns/1ps
`include "stv_defines.vh"
module stv_cal_block (
  input wire cal_clk, // Dedicated calibration clock
  input wire rst, // Synchronous reset, active high
  input wire cal_powerdown, // Asynchronous power-down request
  output reg cal_ready, // Calibration done and powered
  output reg cal_powered // Calibration block powered up
);
  // ------------------------------------------------------------
  // Power-down synchroniser, three stages
  // ------------------------------------------------------------
  reg pd_s1;
  reg pd_s2;
  reg pd_s3;
  reg pd_level;
  reg [1:0] state;
  reg [3:0] settle;
  always @(posedge cal_clk) begin
    pd_s1 <= cal_powerdown;
    pd_s2 <= pd_s1;
    pd_s3 <= pd_s2;
  end
  // Level changes only once stages two and three agree
  always @(posedge cal_clk) begin
    if (rst) begin
      pd_level <= 1'b1;
    end else if (pd_s2 == pd_s3) begin
      pd_level <= pd_s3;
    end
  end
  // ------------------------------------------------------------
  // Calibration sequence
  // ------------------------------------------------------------
  always @(posedge cal_clk) begin
    if (rst) begin
      state <= `STV_CAL_OFF;
      settle <= 4'h0;
      cal_ready <= 1'b0;
      cal_powered <= 1'b0;
    end else if (pd_level) begin
      state <= `STV_CAL_OFF;
      settle <= 4'h0;
      cal_ready <= 1'b0;
      cal_powered <= 1'b0;
    end else begin
      case (state)
        `STV_CAL_OFF: begin
          cal_powered <= 1'b1;
          settle <= 4'h0;
          state <= `STV_CAL_SETTLING;
        end
        `STV_CAL_SETTLING: begin
          settle <= settle + 4'h1;
          if (settle == `STV_CAL_SETTLE - 4'h1) begin
            state <= `STV_CAL_READY;
            cal_ready <= 1'b1;
          end
        end
        `STV_CAL_READY: begin
          cal_ready <= 1'b1;
        end
        default: begin
          state <= `STV_CAL_OFF;
        end
      endcase
    end
  end
endmodule // stv_cal_block

// ---- hdl/stv_status.v ----
// Receiver pattern verifier status flags plus calibration control.
// Assumes verifier events are on clk, the recovered receiver clock,
// and that the receiver digital reset arrives asynchronously.
`timescale 1ns/1ps
`include "stv_defines.vh"
module stv_status (
  input wire clk, // Recovered receiver clock, 50 MHz
  input wire rst, // Synchronous reset, active high
  input wire rx_digital_reset, // Asynchronous receiver digital reset
  input wire test_mode, // 0 self-test, 1 pseudo-random
  input wire verify_enable, // Verifier active
  input wire pattern_cycle_end, // Pulse: full pattern cycle received
  input wire seq_end, // Pulse: one sequence checked
  input wire mismatch, // Pulse: verifier found a mismatch
  input wire cal_clk, // Calibration block clock
  input wire cal_powerdown, // Asynchronous calibration power-down
  output reg test_done, // Verification done flag
  output reg test_error, // Verification error flag
  output reg cal_ready, // Calibration complete
  output reg cal_powered // Calibration block powered
);
  // ------------------------------------------------------------
  // Digital reset synchroniser
  // ------------------------------------------------------------
  reg dr_s1;
  reg dr_s2;
  reg dr_s3;
  reg dig_reset;
  reg [1:0] state;
  reg [1:0] hold_cnt;
  reg seq_err;
  reg next_done;
  reg next_error;
  wire cal_ready_w;
  wire cal_powered_w;
  wire evt_live;
  reg [1:0] next_state;
  reg [1:0] next_hold_cnt;
  reg next_seq_err;
  reg cr_s1;
  reg cr_s2;
  reg cr_s3;
  reg cal_rst;
  always @(posedge clk) begin
    dr_s1 <= rx_digital_reset;
    dr_s2 <= dr_s1;
    dr_s3 <= dr_s2;
  end
  // A pulse of two parallel cycles survives the agreement filter
  always @(posedge clk) begin
    if (rst) begin
      dig_reset <= 1'b1;
    end else if (dr_s2 == dr_s3) begin
      dig_reset <= dr_s3;
    end
  end
  // ------------------------------------------------------------
  // Verifier event gate
  // ------------------------------------------------------------
  // Events before the verifier is enabled belong to no test
  assign evt_live = (state != `STV_ST_IDLE);
  // ------------------------------------------------------------
  // Verifier state
  // ------------------------------------------------------------
  // DONE keeps the gate open so late errors still reach the flags
  always @* begin
    next_state = state;
    case (state)
      `STV_ST_IDLE: begin
        if (verify_enable) begin
          next_state = `STV_ST_RUN;
        end
      end
      `STV_ST_RUN: begin
        if (next_done) begin
          next_state = `STV_ST_DONE;
        end
      end
      `STV_ST_DONE: begin
        next_state = `STV_ST_DONE;
      end
      default: begin
        next_state = `STV_ST_IDLE;
      end
    endcase
  end
  always @(posedge clk) begin
    if (rst || dig_reset) begin
      state <= `STV_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // ------------------------------------------------------------
  // Done flag next value
  // ------------------------------------------------------------
  always @* begin
    next_done = test_done;
    if (evt_live) begin
      if (test_mode == `STV_MODE_SELFTEST) begin
        if (pattern_cycle_end || mismatch) begin
          next_done = 1'b1;
        end
      end else begin
        if (pattern_cycle_end) begin
          next_done = 1'b1;
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Error flag next value
  // ------------------------------------------------------------
  always @* begin
    next_error = test_error;
    if (evt_live) begin
      if (test_mode == `STV_MODE_SELFTEST) begin
        if (mismatch) begin
          next_error = 1'b1;
        end
      end else begin
        // Mismatch wins over a clean release in the same cycle
        if (mismatch) begin
          next_error = 1'b1;
        end else if (seq_end && !seq_err && hold_cnt == 2'h0) begin
          next_error = 1'b0;
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Error hold counter and sequence error tracker
  // ------------------------------------------------------------
  // Reloaded on every mismatch outside IDLE, so a burst restarts the minimum hold
  always @* begin
    next_hold_cnt = hold_cnt;
    if (mismatch && evt_live) begin
      next_hold_cnt = `STV_ERR_HOLD_CYC - 2'h1;
    end else if (hold_cnt != 2'h0) begin
      next_hold_cnt = hold_cnt - 2'h1;
    end
  end
  // A mismatch with seq_end counts in the sequence that is ending
  always @* begin
    next_seq_err = seq_err;
    if (seq_end) begin
      next_seq_err = 1'b0;
    end else if (mismatch) begin
      next_seq_err = 1'b1;
    end
  end
  // ------------------------------------------------------------
  // Flag registers and error hold counter
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst || dig_reset) begin
      test_done <= 1'b0;
    end else begin
      test_done <= next_done;
    end
  end
  always @(posedge clk) begin
    if (rst || dig_reset) begin
      test_error <= 1'b0;
    end else begin
      test_error <= next_error;
    end
  end
  // Cleared with the flags so no stale hold outlives a reset
  always @(posedge clk) begin
    if (rst || dig_reset) begin
      hold_cnt <= 2'h0;
      seq_err <= 1'b0;
    end else begin
      hold_cnt <= next_hold_cnt;
      seq_err <= next_seq_err;
    end
  end
  // ------------------------------------------------------------
  // Calibration reset synchroniser
  // ------------------------------------------------------------
  // The rst input is timed by clk; the calibration clock is unrelated,
  // so the reset is re-timed here like any other outside input
  always @(posedge cal_clk) begin
    cr_s1 <= rst;
    cr_s2 <= cr_s1;
    cr_s3 <= cr_s2;
  end
  // Calibration leaves reset a few calibration clocks after clk does
  always @(posedge cal_clk) begin
    if (cr_s2 == cr_s3) begin
      cal_rst <= cr_s3;
    end
  end
  // ------------------------------------------------------------
  // Calibration block
  // ------------------------------------------------------------
  stv_cal_block u_cal (
    .cal_clk(cal_clk),
    .rst(cal_rst),
    .cal_powerdown(cal_powerdown),
    .cal_ready(cal_ready_w),
    .cal_powered(cal_powered_w)
  );
  // Outputs register from calibration domain; the monitor resynchronises only the done and error flags
  always @(posedge cal_clk) begin
    if (cal_rst) begin
      cal_ready <= 1'b0;
      cal_powered <= 1'b0;
    end else begin
      cal_ready <= cal_ready_w;
      cal_powered <= cal_powered_w;
    end
  end
endmodule // stv_status

// ---- verification/stv_chk.sv ----
// Port assertions for the verifier status block.
// Bound to stv_status from tb_top.
`timescale 1ns/1ps
module stv_chk (
  input wire clk, // Rx clock
  input wire rst, // Reset
  input wire rx_digital_reset, // Rx reset
  input wire test_mode, // Mode
  input wire verify_enable, // Enable
  input wire pattern_cycle_end, // Cycle end
  input wire seq_end, // Seq end
  input wire mismatch, // Mismatch
  input wire cal_clk, // Cal clock
  input wire cal_powerdown, // Cal off
  input wire test_done, // Done
  input wire test_error, // Error
  input wire cal_ready, // Ready
  input wire cal_powered // Powered
);
  // Resets pass a sync, so wait until they have drained
  reg [4:0] drs = 5'h1f;
  wire quiet = !rx_digital_reset && !rst && drs == 5'h0;
  always @(posedge clk) drs <= {drs[3:0], rx_digital_reset | rst};
  done_hold_a: assert property (
    @(posedge clk) disable iff (!quiet) test_done |=> test_done)
    else $error("done dropped");
  cyc_done_a: assert property (
    @(posedge clk) disable iff (!quiet)
    verify_enable && pattern_cycle_end |=> test_done) else $error("no done");
  st_err_a: assert property (
    @(posedge clk) disable iff (!quiet) !test_mode && (test_error ||
    verify_enable && mismatch) |=> test_error && test_done)
    else $error("self-test error");
  prbs_err_a: assert property (
    @(posedge clk) disable iff (!quiet) test_mode && verify_enable &&
    mismatch |=> test_error[*3]) else $error("error too short");
  prbs_clr_a: assert property (
    @(posedge clk) disable iff (!quiet) test_mode && verify_enable &&
    mismatch ##1 (seq_end && !mismatch) ##1 !mismatch[*2] ##1
    (seq_end && !mismatch) |=> !test_error)
    else $error("error not released");
  cal_off_a: assert property (
    @(posedge cal_clk) disable iff (rst) cal_powerdown[*7]
    |-> !cal_powered && !cal_ready) else $error("cal still on");
  cal_up_a: assert property (
    @(posedge cal_clk) disable iff (rst) !cal_powerdown[*8] |-> cal_powered)
    else $error("cal not up");
endmodule // stv_chk

// ---- verification/stv_mon.sv ----
// Fabric-side monitor of the status flags.
// Assumes the flags come from another clock domain.
`timescale 1ns/1ps
module stv_mon (
  input wire mon_clk, // Fabric clock
  input wire test_done, // Done flag
  input wire test_error, // Error flag
  output wire done_s, // Synced done
  output wire err_s // Synced error
);
  // Two flops keep a flag edge away from a metastable sample
  reg [1:0] d_q = 2'h0;
  reg [1:0] e_q = 2'h0;
  always @(posedge mon_clk) begin
    d_q <= {d_q[0], test_done};
    e_q <= {e_q[0], test_error};
  end
  assign done_s = d_q[1];
  assign err_s = e_q[1];
endmodule // stv_mon

// ---- verification/tb_top.sv ----
// Self-checking bench for the verifier status block.
// Assumes stv_status, stv_chk and stv_mon are compiled first.
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0, cal_clk = 1'b0, rst = 1'b1, rx_digital_reset = 1'b0;
  reg test_mode = 1'b0, verify_enable = 1'b0, pattern_cycle_end = 1'b0;
  reg seq_end = 1'b0, mismatch = 1'b0, cal_powerdown = 1'b0;
  wire test_done, test_error, cal_ready, cal_powered, done_s, err_s;
  integer error_cnt = 0, check_count = 0;
  always #10 clk = ~clk;
  always #17 cal_clk = ~cal_clk; // Own unrelated clock
  stv_status dut_u (.clk, .rst, .rx_digital_reset, .test_mode,
    .verify_enable, .pattern_cycle_end, .seq_end, .mismatch, .cal_clk,
    .cal_powerdown, .test_done, .test_error, .cal_ready, .cal_powered);
  stv_mon mon_u (.mon_clk(clk), .test_done, .test_error, .done_s, .err_s);
  task chk(input logic [1:0] seen, input logic [1:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t saw %b want %b", $time, seen, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task pulse(input integer k); // 0 cycle end, 1 seq end, 2 mismatch
    case (k)
      0: pattern_cycle_end = 1'b1;
      1: seq_end = 1'b1;
      default: mismatch = 1'b1;
    endcase
    cyc(1);
    case (k)
      0: pattern_cycle_end = 1'b0;
      1: seq_end = 1'b0;
      default: mismatch = 1'b0;
    endcase
  endtask
  task dreset;
    rx_digital_reset = 1'b1;
    cyc(2); // Shortest legal pulse
    rx_digital_reset = 1'b0;
    cyc(6);
  endtask
  task t_self;
    test_mode = 1'b0;
    dreset;
    pulse(2);
    chk({test_done, test_error}, 2'h3);
    pulse(1);
    cyc(5);
    chk({test_done, test_error}, 2'h3);
    dreset;
    chk({test_done, test_error}, 2'h0);
    pulse(0);
    chk({test_done, test_error}, 2'h2);
    $display("self-test done");
  endtask
  task t_prbs;
    test_mode = 1'b1;
    dreset;
    pulse(2);
    chk({test_done, test_error}, 2'h1);
    pulse(1);
    cyc(2);
    chk({test_done, test_error}, 2'h1);
    pulse(1);
    chk({test_done, test_error}, 2'h0);
    pulse(0);
    cyc(3);
    chk({test_done, test_error}, 2'h2);
    chk({done_s, err_s}, 2'h2);
    $display("prbs done");
  endtask
  task t_cal;
    cal_powerdown = 1'b1;
    repeat (10) @(posedge cal_clk);
    #1;
    chk({cal_powered, cal_ready}, 2'h0);
    cal_powerdown = 1'b0;
    repeat (20) @(posedge cal_clk);
    #1;
    chk({cal_powered, cal_ready}, 2'h3);
    $display("calibration done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst = 1'b0;
    verify_enable = 1'b1;
    t_self;
    t_prbs;
    t_cal;
    stop_test;
  end
  // Tests take about 100 cycles; allow ample margin
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
endmodule // tb_top
bind stv_status stv_chk chk_u (.clk, .rst, .rx_digital_reset, .test_mode,
  .verify_enable, .pattern_cycle_end, .seq_end, .mismatch, .cal_clk,
  .cal_powerdown, .test_done, .test_error, .cal_ready, .cal_powered);
